// file: rtc_cal_pkg.sv
package rtc_cal_pkg;

	// register byte offsets on the plain register port
	localparam logic [7:0] OFF_WEEKDAY_COUNT = 8'h00;
	localparam logic [7:0] OFF_DATE_COUNT    = 8'h04;
	localparam logic [7:0] OFF_MONTH_COUNT   = 8'h08;
	localparam logic [7:0] OFF_YEAR_COUNT    = 8'h0C;
	localparam logic [7:0] OFF_ALARM_BASE    = 8'h10;
	localparam logic [7:0] OFF_ALARM_STEP    = 8'h04;
	localparam logic [7:0] OFF_ALARM_STATUS  = 8'h24;

	// alarm bank entries, in offset order from OFF_ALARM_BASE
	localparam int NUM_ALARMS   = 5;
	localparam int ALM_SECOND   = 0;
	localparam int ALM_MINUTE   = 1;
	localparam int ALM_HOUR     = 2;
	localparam int ALM_WEEKDAY  = 3;
	localparam int ALM_DATE     = 4;

	// field positions
	localparam int ENABLE_BIT = 7;
	localparam int FLAG_BIT   = 0;

	// writable bits of each register; the others read as zero
	localparam logic [7:0] WEEKDAY_MASK = 8'h07;
	localparam logic [7:0] DATE_MASK    = 8'h3F;
	localparam logic [7:0] MONTH_MASK   = 8'h1F;
	localparam logic [7:0] YEAR_MASK    = 8'hFF;
	localparam logic [7:0] VALUE_MASK   = 8'h7F;
	localparam logic [NUM_ALARMS-1:0][7:0] ALARM_MASK =
		{8'hBF, 8'h87, 8'hBF, 8'hFF, 8'hFF};

	// calendar limits, BCD coded
	localparam logic [7:0] WEEKDAY_FIRST = 8'h00;
	localparam logic [7:0] WEEKDAY_LAST  = 8'h06;
	localparam logic [7:0] DATE_FIRST    = 8'h01;
	localparam logic [7:0] MONTH_FIRST   = 8'h01;
	localparam logic [7:0] MONTH_LAST    = 8'h12;
	localparam logic [7:0] YEAR_FIRST    = 8'h00;
	localparam logic [7:0] YEAR_LAST     = 8'h99;
	localparam logic [7:0] FEBRUARY      = 8'h02;
	localparam logic [7:0] APRIL         = 8'h04;
	localparam logic [7:0] JUNE          = 8'h06;
	localparam logic [7:0] SEPTEMBER     = 8'h09;
	localparam logic [7:0] NOVEMBER      = 8'h11;
	localparam logic [7:0] DAYS_28       = 8'h28;
	localparam logic [7:0] DAYS_29       = 8'h29;
	localparam logic [7:0] DAYS_30       = 8'h30;
	localparam logic [7:0] DAYS_31       = 8'h31;
	localparam logic [3:0] BCD_NINE      = 4'h9;
	localparam logic [1:0] LEAP_MASK     = 2'h3;

	// reset values
	localparam logic [7:0] RDATA_RESET  = 8'h00;
	localparam logic       FLAG_RESET   = 1'b0;
	localparam logic       ENABLE_RESET = 1'b0;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] weekday;
	} calendar_t;

	typedef struct packed {
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} clock_time_t;

	typedef logic [NUM_ALARMS-1:0][7:0] alarm_bank_t;

	typedef struct packed {
		calendar_t   cal;
		alarm_bank_t alarm;
		logic        flag;
		logic [7:0]  rdata;
	} state_t;

endpackage

// file: rtc_calendar_alarm.sv
`timescale 1ns/100ps
module rtc_calendar_alarm
(
	input  wire logic                    ref_clk_in,    // 100 MHz clock
	input  wire logic                    reset_n_in,    // power-on reset
	input  wire logic [7:0]              addr_in,       // register address
	input  wire logic [7:0]              wdata_in,      // write data
	input  wire logic                    wr_in,         // write strobe
	input  wire logic                    rd_in,         // read strobe
	output logic      [7:0]              rdata_out,     // read data
	input  wire logic                    run_in,        // run/stop bit
	input  wire logic                    day_carry_in,  // hour rollover
	input  wire rtc_cal_pkg::clock_time_t time_in,      // sec/min/hour
	output rtc_cal_pkg::calendar_t       calendar_out,  // calendar
	output logic                         alarm_flag_out // match flag
);
	import rtc_cal_pkg::*;

	state_t                    state_reg;
	state_t                    state_next;
	alarm_bank_t               count_vec;
	logic [NUM_ALARMS-1:0]     field_ok;
	logic [NUM_ALARMS-1:0]     enables;
	logic                      any_enabled;
	logic                      alarm_match;

	// add one to a two-digit BCD value; the caller handles wrap limits
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] >= BCD_NINE)
		begin
			r[3:0] = 4'h0;
			r[7:4] = v[7:4] + 4'h1;
		end
		else
		begin
			r[3:0] = v[3:0] + 4'h1;
		end
		return r;
	endfunction

	// tens*10 + units mod 4 equals (2*tens + units) mod 4
	function automatic logic is_leap(input logic [7:0] year);
		logic [1:0] rem;
		rem = ({year[4], 1'b0} + year[1:0]) & LEAP_MASK;
		return rem == 2'h0;
	endfunction

	// last day of the month as BCD, month 00 treated as a long month
	function automatic logic [7:0] last_day(input logic [7:0] month,
		input logic leap);
		logic [7:0] d;
		d = DAYS_31;
		if (month == FEBRUARY)
		begin
			d = leap ? DAYS_29 : DAYS_28;
		end
		else if (month == APRIL || month == JUNE ||
			month == SEPTEMBER || month == NOVEMBER)
		begin
			d = DAYS_30;
		end
		return d;
	endfunction

	// live counter values lined up with the alarm bank entries
	assign count_vec[ALM_SECOND]  = time_in.second;
	assign count_vec[ALM_MINUTE]  = time_in.minute;
	assign count_vec[ALM_HOUR]    = time_in.hour;
	assign count_vec[ALM_WEEKDAY] = state_reg.cal.weekday;
	assign count_vec[ALM_DATE]    = state_reg.cal.date;

	// per-field compare; a disabled field never blocks the match
	genvar gi;
	generate
		for (gi = 0; gi < NUM_ALARMS; gi++)
		begin : g_cmp
			logic [7:0] diff;
			assign enables[gi] = state_reg.alarm[gi][ENABLE_BIT];
			assign diff = (state_reg.alarm[gi] ^ count_vec[gi]) &
				ALARM_MASK[gi] & VALUE_MASK;
			assign field_ok[gi] = !enables[gi] || (diff == 8'h00);
		end
	endgenerate

	// an empty enable set would make the AND true, hence the extra term
	assign any_enabled = |enables;
	assign alarm_match = any_enabled && (&field_ok);

	// next state: counting, register writes, flag and read data
	always_comb
	begin
		logic       day_step;
		logic       month_step;
		logic       year_step;
		logic [7:0] month_end;
		logic       status_wr;
		day_step   = 1'b0;
		month_step = 1'b0;
		year_step  = 1'b0;
		month_end  = DAYS_31;
		status_wr  = 1'b0;
		state_next = state_reg;

		// counting is gated here even if the carry source is gated too
		day_step  = day_carry_in && run_in;
		month_end = last_day(state_reg.cal.month,
			is_leap(state_reg.cal.year));

		if (day_step)
		begin
			// weekday follows each completed day
			if (state_reg.cal.weekday >= WEEKDAY_LAST)
			begin
				state_next.cal.weekday = WEEKDAY_FIRST;
			end
			else
			begin
				state_next.cal.weekday =
					state_reg.cal.weekday + 8'h01;
			end

			// date steps on each day carry and wraps after month end
			if (state_reg.cal.date >= month_end)
			begin
				state_next.cal.date = DATE_FIRST;
				month_step = 1'b1;
			end
			else
			begin
				state_next.cal.date = bcd_inc(state_reg.cal.date);
			end
		end

		// month carry from the date counter
		if (month_step)
		begin
			if (state_reg.cal.month >= MONTH_LAST)
			begin
				state_next.cal.month = MONTH_FIRST;
				year_step = 1'b1;
			end
			else
			begin
				state_next.cal.month = bcd_inc(state_reg.cal.month);
			end
		end

		// year carry from the month counter
		if (year_step)
		begin
			if (state_reg.cal.year >= YEAR_LAST)
			begin
				state_next.cal.year = YEAR_FIRST;
			end
			else
			begin
				state_next.cal.year = bcd_inc(state_reg.cal.year);
			end
		end

		// software writes win over counting; software stops the count
		// first, so the collision only happens on misuse
		if (wr_in)
		begin
			case (addr_in)
				OFF_WEEKDAY_COUNT:
				begin
					state_next.cal.weekday = wdata_in & WEEKDAY_MASK;
				end
				OFF_DATE_COUNT:
				begin
					state_next.cal.date = wdata_in & DATE_MASK;
				end
				OFF_MONTH_COUNT:
				begin
					state_next.cal.month = wdata_in & MONTH_MASK;
				end
				OFF_YEAR_COUNT:
				begin
					state_next.cal.year = wdata_in & YEAR_MASK;
				end
				OFF_ALARM_STATUS:
				begin
					status_wr = 1'b1;
				end
				default:
				begin
					state_next = state_next;
				end
			endcase

			// alarm bank; reserved bits are masked off so they read zero
			for (int i = 0; i < NUM_ALARMS; i++)
			begin
				if (addr_in == OFF_ALARM_BASE + OFF_ALARM_STEP * 8'(i))
				begin
					state_next.alarm[i] = wdata_in & ALARM_MASK[i];
				end
			end
		end

		// writing one leaves the flag alone; a match wins over a clear
		if (alarm_match)
		begin
			state_next.flag = 1'b1;
		end
		else if (status_wr && !wdata_in[FLAG_BIT])
		begin
			state_next.flag = 1'b0;
		end

		// read data stands only in the cycle after the strobe
		state_next.rdata = RDATA_RESET;
		if (rd_in)
		begin
			case (addr_in)
				OFF_WEEKDAY_COUNT:
				begin
					state_next.rdata = state_reg.cal.weekday & WEEKDAY_MASK;
				end
				OFF_DATE_COUNT:
				begin
					state_next.rdata = state_reg.cal.date & DATE_MASK;
				end
				OFF_MONTH_COUNT:
				begin
					state_next.rdata = state_reg.cal.month & MONTH_MASK;
				end
				OFF_YEAR_COUNT:
				begin
					state_next.rdata = state_reg.cal.year;
				end
				OFF_ALARM_STATUS:
				begin
					state_next.rdata = {7'h00, state_reg.flag};
				end
				default:
				begin
					state_next.rdata = RDATA_RESET;
				end
			endcase
			for (int i = 0; i < NUM_ALARMS; i++)
			begin
				if (addr_in == OFF_ALARM_BASE + OFF_ALARM_STEP * 8'(i))
				begin
					state_next.rdata = state_reg.alarm[i] & ALARM_MASK[i];
				end
			end
		end

		// reset touches only enables, flag and read data; calendar and
		// alarm values survive so the time of day is never lost, and a
		// software write during reset still lands in the calendar
		if (!reset_n_in)
		begin
			for (int i = 0; i < NUM_ALARMS; i++)
			begin
				state_next.alarm[i][ENABLE_BIT] = ENABLE_RESET;
			end
			state_next.flag  = FLAG_RESET;
			state_next.rdata = RDATA_RESET;
		end
	end

	// the one state register; reset is applied in the next-state logic
	always_ff @(posedge ref_clk_in)
	begin
		state_reg <= state_next;
	end

	// outputs straight from flip-flops
	assign rdata_out      = state_reg.rdata;
	assign calendar_out   = state_reg.cal;
	assign alarm_flag_out = state_reg.flag;

endmodule

// file: rtc_cal_checker.sv
`timescale 1ns/100ps
module rtc_cal_checker
	import rtc_cal_pkg::*;
(
	input wire logic       ref_clk_in,     // clock
	input wire logic       reset_n_in,     // reset
	input wire logic [7:0] addr_in,        // address
	input wire logic [7:0] wdata_in,       // write data
	input wire logic       wr_in,          // write strobe
	input wire logic       rd_in,          // read strobe
	input wire logic [7:0] rdata_out,      // read data
	input wire logic       run_in,         // run bit
	input wire logic       day_carry_in,   // day carry
	input wire calendar_t  calendar_out,   // calendar
	input wire logic       alarm_flag_out  // flag
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	// a counted day: a write in the same cycle would win instead
	sequence day_step;
		run_in && day_carry_in && !wr_in;
	endsequence

	wk_read_a: assert property (rd_in && addr_in == OFF_WEEKDAY_COUNT
		|=> rdata_out == $past(calendar_out.weekday))
		else $error("weekday read wrong");
	date_read_a: assert property (rd_in && addr_in == OFF_DATE_COUNT
		|=> rdata_out[7:6] == 2'h0)
		else $error("date top bits set");
	wk_step_a: assert property (day_step ##0 calendar_out.weekday != 8'h06
		|=> calendar_out.weekday == $past(calendar_out.weekday) + 8'h01)
		else $error("weekday missed step");
	wk_wrap_a: assert property (day_step ##0 calendar_out.weekday == 8'h06
		|=> calendar_out.weekday == 8'h00)
		else $error("weekday missed wrap");
	date_step_a: assert property (day_step ##0 calendar_out.date == 8'h15
		|=> calendar_out.date == 8'h16)
		else $error("date missed step");
	new_year_a: assert property (day_step ##0 calendar_out[31:8] == 24'h991231
		|=> calendar_out[31:8] == 24'h000101)
		else $error("year end wrong");
	run_gate_a: assert property (!run_in && !wr_in
		|=> $stable(calendar_out))
		else $error("calendar moved while stopped");
	flag_clear_a: assert property ($fell(alarm_flag_out) |->
		$past(wr_in && addr_in == OFF_ALARM_STATUS && !wdata_in[FLAG_BIT]))
		else $error("flag fell without clear");
	flag_reset_a: assert property (disable iff (1'b0) !reset_n_in
		|=> !alarm_flag_out)
		else $error("flag kept through reset");
endmodule

bind rtc_calendar_alarm rtc_cal_checker i_rtc_cal_checker (
	.ref_clk_in     (ref_clk_in),
	.reset_n_in     (reset_n_in),
	.addr_in        (addr_in),
	.wdata_in       (wdata_in),
	.wr_in          (wr_in),
	.rd_in          (rd_in),
	.rdata_out      (rdata_out),
	.run_in         (run_in),
	.day_carry_in   (day_carry_in),
	.calendar_out   (calendar_out),
	.alarm_flag_out (alarm_flag_out)
);

// file: tb.sv
`timescale 1ns/100ps
module tb;
	import rtc_cal_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wd = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        run = 1'b0;
	logic        carry = 1'b0;
	clock_time_t tm = 24'h123456;
	logic [7:0]  rdata;
	calendar_t   cal;
	logic        flag;
	int          n_errors = 0;
	int          n_compared = 0;
	logic [7:0]  mk [9] = '{8'h07, 8'h3F, 8'h1F, 8'hFF, 8'hFF, 8'hFF,
		8'hBF, 8'h87, 8'hBF};
	calendar_t   ci [6] = '{32'h03022806, 32'h04022801, 32'h00022902,
		32'h21043003, 32'h99123105, 32'h19071504};
	calendar_t   co [6] = '{32'h03030100, 32'h04022902, 32'h00030103,
		32'h21050104, 32'h00010106, 32'h19071605};

	rtc_calendar_alarm i_rtc_calendar_alarm (
		.ref_clk_in     (clk),
		.reset_n_in     (rst_n),
		.addr_in        (addr),
		.wdata_in       (wd),
		.wr_in          (wr),
		.rd_in          (rd),
		.rdata_out      (rdata),
		.run_in         (run),
		.day_carry_in   (carry),
		.time_in        (tm),
		.calendar_out   (cal),
		.alarm_flag_out (flag)
	);

	initial
	begin
		forever #5 clk = ~clk;
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe edge
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	// counting is stopped first, since writes do not sync with a carry;
	// every value loaded here lies inside its legal BCD range
	task set_cal(input calendar_t c);
		run <= 1'b0;
		wr_reg(OFF_WEEKDAY_COUNT, c.weekday);
		wr_reg(OFF_DATE_COUNT, c.date);
		wr_reg(OFF_MONTH_COUNT, c.month);
		wr_reg(OFF_YEAR_COUNT, c.year);
	endtask

	task step(input logic r);
		@(posedge clk);
		run <= r;
		carry <= 1'b1;
		@(posedge clk);
		carry <= 1'b0;
		run <= 1'b0;
		#1;
	endtask

	task end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// guards against a hung run
	initial
	begin
		repeat (4000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	initial
	begin
		// counters have no reset value, so load them inside reset
		set_cal(32'h21041503);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++)
			wr_reg(8'(4 * i), 8'hFF);
		for (int i = 0; i < 9; i++)
			rd_chk(8'(4 * i), mk[i]);
		rd_chk(8'h30, 8'h00);
		$display("register masks done");
		for (int i = 0; i < 6; i++)
		begin
			set_cal(ci[i]);
			step(1'b1);
			chk(cal, co[i]);
		end
		step(1'b0);
		chk(cal, co[5]);
		$display("calendar counting done");
		set_cal(32'h21041503);
		wr_reg(8'h10, 8'hD6);
		wr_reg(8'h14, 8'hB4);
		wr_reg(8'h18, 8'h92);
		wr_reg(8'h1C, 8'h83);
		wr_reg(8'h20, 8'h95);
		wr_reg(OFF_ALARM_STATUS, 8'h00);
		rd_chk(OFF_ALARM_STATUS, 8'h01);
		tm <= 24'h123457;
		wr_reg(OFF_ALARM_STATUS, 8'h00);
		rd_chk(OFF_ALARM_STATUS, 8'h00);
		wr_reg(8'h10, 8'h57);
		@(posedge clk);
		rd_chk(OFF_ALARM_STATUS, 8'h01);
		wr_reg(8'h1C, 8'h84);
		wr_reg(OFF_ALARM_STATUS, 8'h00);
		wr_reg(OFF_ALARM_STATUS, 8'h01);
		rd_chk(OFF_ALARM_STATUS, 8'h00);
		$display("alarm compare done");
		// second reset in mid-run: enables drop, values and calendar stay
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk(cal, 32'h21041503);
		rd_chk(OFF_ALARM_STATUS, 8'h00);
		rd_chk(8'h20, 8'h15);
		rd_chk(8'h18, 8'h12);
		$display("reset retention done");
		end_sim();
	end
endmodule
